// ---- rtl/css_select.sv ----
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps


module css_select (
    input wire logic clk_sys,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // digital input terminal levels, active high
    input wire logic [css_pkg::TERM_N-1:0] di_level,
    // local sources
    input wire logic [css_pkg::FREQ_W-1:0] local_freq,
    input wire logic multistep_on,
    input wire logic [css_pkg::FREQ_W-1:0] multistep_freq,
    input wire logic [css_pkg::RUN_W-1:0] keypad_run,
    input wire logic [css_pkg::RUN_W-1:0] di_run,
    // remote sources
    input wire css_pkg::css_cmd_t ser1_cmd,
    input wire css_pkg::css_cmd_t ser2_cmd,
    input wire css_pkg::css_cmd_t fieldbus_cmd,
    input wire css_pkg::css_cmd_t can_cmd,
    // routed commands
    output logic [css_pkg::FREQ_W-1:0] freq_cmd,
    output logic [css_pkg::RUN_W-1:0] run_cmd,
    output css_pkg::css_src_t freq_src,
    output css_pkg::css_src_t run_src
);

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic [css_pkg::CFG_W-1:0] cfg;
    logic [css_pkg::TERM_W-1:0] term_fn [css_pkg::TERM_N];
    logic [3:0] serial_source_select;
    logic [1:0] fieldbus_source_select;
    logic can_link_enable;
    logic local_run_source;

    assign serial_source_select =
        cfg[css_pkg::CFG_SER_POS +: css_pkg::CFG_SER_W];
    assign fieldbus_source_select =
        cfg[css_pkg::CFG_BUS_POS +: css_pkg::CFG_BUS_W];
    assign can_link_enable = cfg[css_pkg::CFG_CAN_POS];
    assign local_run_source = cfg[css_pkg::CFG_RUNSRC_POS];

    // software writes the selector settings
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            cfg <= css_pkg::CFG_RESET;
        else if (reg_wr && reg_addr == css_pkg::OFS_CFG)
            cfg <= reg_wdata[css_pkg::CFG_W-1:0];
    end

    // terminal function codes: four in the low word, the fifth above
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < css_pkg::TERM_N; i++)
                term_fn[i] <= css_pkg::TERM_RESET;
        end
        else if (reg_wr && reg_addr == css_pkg::OFS_TERM_LO)
        begin
            for (int i = 0; i < 4; i++)
                term_fn[i] <= reg_wdata[i*8 +: 8];
        end
        else if (reg_wr && reg_addr == css_pkg::OFS_TERM_HI)
            term_fn[4] <= reg_wdata[7:0];
    end

    // ------------------------------------------------------------
    // link operation input
    // ------------------------------------------------------------
    logic [css_pkg::TERM_N-1:0] term_is_link;
    logic link_assigned;
    logic link_active;
    logic link_on;

    for (genvar g = 0; g < css_pkg::TERM_N; g++)
    begin : g_term
        assign term_is_link[g] = (term_fn[g] == css_pkg::FN_LINK_OP);
    end

    assign link_assigned = |term_is_link;
    // any assigned terminal that is high turns the link operation on
    assign link_active = |(term_is_link & di_level);
    // unassigned counts as permanently on
    assign link_on = !link_assigned || link_active;

    // ------------------------------------------------------------
    // source decision
    // ------------------------------------------------------------
    css_pkg::css_src_t ser_freq;
    css_pkg::css_src_t ser_run;
    css_pkg::css_src_t next_freq_src;
    css_pkg::css_src_t next_run_src;

    // serial selector decode; codes above the top act as code 0
    always_comb
    begin
        case (serial_source_select)
            4'h1, 4'h3, 4'h7: ser_freq = css_pkg::CSS_SRC_SER1;
            4'h4, 4'h5, 4'h8: ser_freq = css_pkg::CSS_SRC_SER2;
            default: ser_freq = css_pkg::CSS_SRC_LOCAL;
        endcase
        case (serial_source_select)
            4'h2, 4'h3, 4'h5: ser_run = css_pkg::CSS_SRC_SER1;
            4'h6, 4'h7, 4'h8: ser_run = css_pkg::CSS_SRC_SER2;
            default: ser_run = css_pkg::CSS_SRC_LOCAL;
        endcase
    end

    // fieldbus bits override the serial choice, link off forces local
    always_comb
    begin
        next_freq_src = ser_freq;
        next_run_src = ser_run;
        if (fieldbus_source_select[0])
            next_freq_src = css_pkg::CSS_SRC_BUS;
        if (fieldbus_source_select[1])
            next_run_src = css_pkg::CSS_SRC_BUS;
        if (!link_on)
        begin
            next_freq_src = css_pkg::CSS_SRC_LOCAL;
            next_run_src = css_pkg::CSS_SRC_LOCAL;
        end
    end

    // ------------------------------------------------------------
    // candidate commands
    // ------------------------------------------------------------
    css_pkg::css_cmd_t bus_cmd;
    logic [css_pkg::FREQ_W-1:0] loc_freq;
    logic [css_pkg::RUN_W-1:0] loc_run;

    // built-in CAN stands in for the fieldbus option when enabled
    assign bus_cmd = can_link_enable ? can_cmd : fieldbus_cmd;
    assign loc_freq = multistep_on ? multistep_freq : local_freq;
    assign loc_run = local_run_source ? di_run : keypad_run;

    // ------------------------------------------------------------
    // registered routing
    // ------------------------------------------------------------
    // outputs follow the decision one cycle later, glitch free
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            freq_src <= css_pkg::CSS_SRC_LOCAL;
            run_src <= css_pkg::CSS_SRC_LOCAL;
        end
        else
        begin
            freq_src <= next_freq_src;
            run_src <= next_run_src;
        end
    end

    css_src_mux #(
        .W(css_pkg::FREQ_W)
    ) u_freq_mux (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .sel(next_freq_src),
        .d_local(loc_freq),
        .d_ser1(ser1_cmd.freq),
        .d_ser2(ser2_cmd.freq),
        .d_bus(bus_cmd.freq),
        .q(freq_cmd)
    );

    css_src_mux #(
        .W(css_pkg::RUN_W)
    ) u_run_mux (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .sel(next_run_src),
        .d_local(loc_run),
        .d_ser1(ser1_cmd.run),
        .d_ser2(ser2_cmd.run),
        .d_bus(bus_cmd.run),
        .q(run_cmd)
    );

    // ------------------------------------------------------------
    // register read-back
    // ------------------------------------------------------------
    // data stand only in the cycle after the read strobe
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            reg_rdata <= 32'h0000_0000;
        else if (!reg_rd)
            reg_rdata <= 32'h0000_0000;
        else
            case (reg_addr)
                css_pkg::OFS_CFG:
                    reg_rdata <= {24'h00_0000, cfg};
                css_pkg::OFS_TERM_LO:
                    reg_rdata <= {term_fn[3], term_fn[2], term_fn[1],
                                  term_fn[0]};
                css_pkg::OFS_TERM_HI:
                    reg_rdata <= {24'h00_0000, term_fn[4]};
                css_pkg::OFS_STATUS:
                begin
                    reg_rdata <= 32'h0000_0000;
                    reg_rdata[css_pkg::ST_FSRC_POS +: 2] <= freq_src;
                    reg_rdata[css_pkg::ST_RSRC_POS +: 2] <= run_src;
                    reg_rdata[css_pkg::ST_LINK_POS] <= link_on;
                    reg_rdata[css_pkg::ST_ASGN_POS] <= link_assigned;
                end
                default:
                    reg_rdata <= 32'h0000_0000;
            endcase
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_link_on;
        (!link_assigned || link_active);
    endsequence

    sequence s_serial_only;
        s_link_on ##0 (fieldbus_source_select == css_pkg::BUS_FOLLOW);
    endsequence

    property p_freq_port1;
        s_serial_only ##0 (serial_source_select inside {4'h1, 4'h3, 4'h7})
        |=> freq_src == css_pkg::CSS_SRC_SER1
            && freq_cmd == $past(ser1_cmd.freq);
    endproperty
    a_freq_port1: assert property (p_freq_port1)
        else $error("frequency not from serial port 1");

    property p_freq_port2;
        s_serial_only ##0 (serial_source_select inside {4'h4, 4'h5, 4'h8})
        |=> freq_cmd == $past(ser2_cmd.freq);
    endproperty
    a_freq_port2: assert property (p_freq_port2)
        else $error("frequency not from serial port 2");

    property p_run_port1;
        s_serial_only ##0 (serial_source_select inside {4'h2, 4'h3, 4'h5})
        |=> run_src == css_pkg::CSS_SRC_SER1 && run_cmd == $past(ser1_cmd.run);
    endproperty
    a_run_port1: assert property (p_run_port1)
        else $error("run command not from serial port 1");

    property p_run_port2;
        s_serial_only ##0 (serial_source_select inside {4'h6, 4'h7, 4'h8})
        |=> run_cmd == $past(ser2_cmd.run);
    endproperty
    a_run_port2: assert property (p_run_port2)
        else $error("run command not from serial port 2");

    property p_bus_override;
        s_link_on ##0 (fieldbus_source_select == css_pkg::BUS_BOTH)
        |=> freq_src == css_pkg::CSS_SRC_BUS && run_src == freq_src;
    endproperty
    a_bus_override: assert property (p_bus_override)
        else $error("fieldbus code 3 did not take both commands");

    property p_bus_run_only;
        s_link_on ##0 (fieldbus_source_select == css_pkg::BUS_RUN)
        ##0 (serial_source_select == 4'h1) |=> run_src == css_pkg::CSS_SRC_BUS
        && freq_src == css_pkg::CSS_SRC_SER1;
    endproperty
    a_bus_run_only: assert property (p_bus_run_only)
        else $error("fieldbus code 2 routed wrongly");

    property p_can_swap;
        s_link_on ##0 fieldbus_source_select[0] ##0 can_link_enable
        |=> freq_cmd == $past(can_cmd.freq);
    endproperty
    a_can_swap: assert property (p_can_swap)
        else $error("CAN link not used for fieldbus frequency");

    property p_link_off_local;
        (link_assigned && !link_active)
        |=> freq_src == css_pkg::CSS_SRC_LOCAL
            && run_src == css_pkg::CSS_SRC_LOCAL
            && freq_cmd == $past(loc_freq);
    endproperty
    a_link_off_local: assert property (p_link_off_local)
        else $error("link off but commands not local");

    property p_unassigned_on;
        (term_is_link == '0) && fieldbus_source_select[0]
        |=> freq_src == css_pkg::CSS_SRC_BUS;
    endproperty
    a_unassigned_on: assert property (p_unassigned_on)
        else $error("unassigned link input did not act as on");

    property p_term_code;
        (term_fn[2] == css_pkg::FN_LINK_OP) && !di_level[2]
        && (term_fn[0] != css_pkg::FN_LINK_OP || !di_level[0])
        && (term_fn[1] != css_pkg::FN_LINK_OP || !di_level[1])
        && (term_fn[3] != css_pkg::FN_LINK_OP || !di_level[3])
        && (term_fn[4] != css_pkg::FN_LINK_OP || !di_level[4])
        |=> run_src == css_pkg::CSS_SRC_LOCAL;
    endproperty
    a_term_code: assert property (p_term_code)
        else $error("terminal code 24 low did not force local");

    property p_local_run;
        (next_run_src == css_pkg::CSS_SRC_LOCAL) && local_run_source
        |=> run_cmd == $past(di_run);
    endproperty
    a_local_run: assert property (p_local_run)
        else $error("local run not from digital inputs");

    property p_follow;
        1'b1 |=> freq_src == $past(next_freq_src)
            && run_src == $past(next_run_src);
    endproperty
    a_follow: assert property (p_follow)
        else $error("routing did not follow in one cycle");

endmodule : css_select

// ---- rtl/css_src_mux.sv ----
`timescale 1ns/1ps

module css_src_mux #(
    parameter int W = 16
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [1:0] sel,
    input wire logic [W-1:0] d_local,
    input wire logic [W-1:0] d_ser1,
    input wire logic [W-1:0] d_ser2,
    input wire logic [W-1:0] d_bus,
    output logic [W-1:0] q
);

    // ------------------------------------------------------------
    // registered four-way pick
    // ------------------------------------------------------------
    // the flop keeps decode hazards off the routed command
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            q <= '0;
        else
            case (sel)
                2'h0: q <= d_local;
                2'h1: q <= d_ser1;
                2'h2: q <= d_ser2;
                default: q <= d_bus;
            endcase
    end

endmodule : css_src_mux

// ---- shared/css_pkg.sv ----
package css_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_TERM_LO = 8'h04;
    localparam logic [7:0] OFS_TERM_HI = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;

    // ------------------------------------------------------------
    // configuration fields
    // ------------------------------------------------------------
    localparam int CFG_SER_POS = 0;
    localparam int CFG_SER_W = 4;
    localparam int CFG_BUS_POS = 4;
    localparam int CFG_BUS_W = 2;
    localparam int CFG_CAN_POS = 6;
    localparam int CFG_RUNSRC_POS = 7;
    localparam int CFG_W = 8;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // terminal function codes, one byte per digital input terminal
    localparam int TERM_N = 5;
    localparam int TERM_W = 8;
    localparam logic [TERM_W-1:0] TERM_RESET = 8'h00;
    localparam logic [TERM_W-1:0] FN_LINK_OP = 8'h18;

    // ------------------------------------------------------------
    // status fields
    // ------------------------------------------------------------
    localparam int ST_FSRC_POS = 0;
    localparam int ST_RSRC_POS = 2;
    localparam int ST_LINK_POS = 4;
    localparam int ST_ASGN_POS = 5;

    // ------------------------------------------------------------
    // selector codes
    // ------------------------------------------------------------
    localparam logic [3:0] SER_MAX = 4'h8;
    localparam logic [1:0] BUS_FOLLOW = 2'h0;
    localparam logic [1:0] BUS_FREQ = 2'h1;
    localparam logic [1:0] BUS_RUN = 2'h2;
    localparam logic [1:0] BUS_BOTH = 2'h3;

    // command source feeding a routed output
    typedef enum logic [1:0]
    {
        CSS_SRC_LOCAL = 2'h0,
        CSS_SRC_SER1 = 2'h1,
        CSS_SRC_SER2 = 2'h2,
        CSS_SRC_BUS = 2'h3
    } css_src_t;

    localparam int FREQ_W = 16;
    localparam int RUN_W = 2;

    // one command set from one source
    typedef struct packed
    {
        logic [FREQ_W-1:0] freq;
        logic [RUN_W-1:0] run;
    } css_cmd_t;

endpackage : css_pkg

// ---- tb/command_source_select_test.sv ----
`timescale 1ns/1ps

module command_source_select_test;
    logic clk_sys;
    logic rst_b;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic [4:0] di_level;
    logic [15:0] local_freq;
    logic multistep_on;
    logic [15:0] multistep_freq;
    logic [1:0] keypad_run;
    logic [1:0] di_run;
    css_pkg::css_cmd_t ser1_cmd, ser2_cmd, fieldbus_cmd, can_cmd;
    logic [15:0] freq_cmd;
    logic [1:0] run_cmd;
    css_pkg::css_src_t freq_src;
    css_pkg::css_src_t run_src;
    logic slow;
    logic hold;
    logic chk;
    logic [7:0] cfg;
    logic [7:0] term [5];
    int e_freq, e_run, e_fs, e_rs, e_lk, e_as;
    int n_mismatch;
    int n_compared;

    css_select dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .di_level(di_level),
        .local_freq(local_freq), .multistep_on(multistep_on),
        .multistep_freq(multistep_freq), .keypad_run(keypad_run),
        .di_run(di_run), .ser1_cmd(ser1_cmd), .ser2_cmd(ser2_cmd),
        .fieldbus_cmd(fieldbus_cmd), .can_cmd(can_cmd),
        .freq_cmd(freq_cmd), .run_cmd(run_cmd), .freq_src(freq_src),
        .run_src(run_src));

    css_remote_model remote (.clk_sys(clk_sys), .rst_b(rst_b), .slow(slow),
        .ser1_cmd(ser1_cmd), .ser2_cmd(ser2_cmd),
        .fieldbus_cmd(fieldbus_cmd), .can_cmd(can_cmd));

    // ------------------------------------------------------------
    // reference model
    // ------------------------------------------------------------
    function automatic void calc();
        int s;
        bit on;
        s = (cfg[3:0] > 8) ? 0 : cfg[3:0];
        on = 0;
        e_as = 0;
        for (int i = 0; i < 5; i++)
            if (term[i] == 24)
            begin
                e_as = 1;
                on = on | di_level[i];
            end
        e_lk = !e_as || on;
        e_fs = (s inside {1, 3, 7}) ? 1 : (s inside {4, 5, 8}) ? 2 : 0;
        e_rs = (s inside {2, 3, 5}) ? 1 : (s inside {6, 7, 8}) ? 2 : 0;
        if (cfg[4])
            e_fs = 3;
        if (cfg[5])
            e_rs = 3;
        if (!e_lk)
        begin
            e_fs = 0;
            e_rs = 0;
        end
        case (e_fs)
            0: e_freq = multistep_on ? multistep_freq : local_freq;
            1: e_freq = ser1_cmd.freq;
            2: e_freq = ser2_cmd.freq;
            default: e_freq = cfg[6] ? can_cmd.freq : fieldbus_cmd.freq;
        endcase
        case (e_rs)
            0: e_run = cfg[7] ? di_run : keypad_run;
            1: e_run = ser1_cmd.run;
            2: e_run = ser2_cmd.run;
            default: e_run = cfg[6] ? can_cmd.run : fieldbus_cmd.run;
        endcase
    endfunction : calc

    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // decision from pre-edge inputs, then mirror of the register writes
    always @(posedge clk_sys)
    begin
        chk <= rst_b;
        calc();
        if (!rst_b)
        begin
            cfg = 8'h00;
            term = '{default: 8'h00};
        end
        else if (reg_wr && reg_addr == 8'h00)
            cfg = reg_wdata[7:0];
        else if (reg_wr && reg_addr == 8'h04)
            {term[3], term[2], term[1], term[0]} = reg_wdata;
        else if (reg_wr && reg_addr == 8'h08)
            term[4] = reg_wdata[7:0];
    end

    // routed outputs lag the inputs by exactly one edge
    always @(negedge clk_sys)
        if (chk)
        begin
            check("freq_cmd", e_freq, freq_cmd);
            check("run_cmd", e_run, run_cmd);
            check("freq_src", e_fs, freq_src);
            check("run_src", e_rs, run_src);
        end

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    always @(posedge clk_sys)
        if (rst_b)
        begin
            if (!hold)
                di_level <= 5'($urandom);
            local_freq <= 16'($urandom);
            multistep_on <= 1'($urandom);
            multistep_freq <= 16'($urandom);
            keypad_run <= 2'($urandom);
            di_run <= 2'($urandom);
        end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        check("reg_rdata", e, reg_rdata);
        @(negedge clk_sys);
        check("reg_rdata idle", 32'h0, reg_rdata);
    endtask : rd

    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // cut a hang well beyond the expected run length
    initial
    begin
        repeat (30000) @(posedge clk_sys);
        n_mismatch++;
        $display("watchdog expired");
        conclude();
    end

    initial
    begin
        {rst_b, reg_wr, reg_rd, slow, hold, chk} = '0;
        {reg_addr, reg_wdata, di_level, local_freq} = '0;
        {multistep_on, multistep_freq, keypad_run, di_run} = '0;
        n_mismatch = 0;
        n_compared = 0;
        void'($urandom(22827));
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        // reset values and an unmapped place
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        wr(8'h10, 32'hFFFF_FFFF);
        rd(8'h10, 32'h0);
        rd(8'h00, 32'h0);
        $display("test registers done");
        // every code pairing, no terminal assigned to link operation
        for (int c = 0; c < 256; c++)
        begin
            wr(8'h00, 32'(c));
            repeat (4) @(posedge clk_sys);
        end
        $display("test code table done");
        // terminal 0 holds a neighbouring code, terminals 2 and 4 link
        wr(8'h04, 32'h0018_0017);
        wr(8'h08, 32'h0000_0018);
        rd(8'h04, 32'h0018_0017);
        slow <= 1'b1;
        for (int i = 0; i < 64; i++)
        begin
            wr(8'h00, 32'($urandom) & 32'hFF);
            repeat (6) @(posedge clk_sys);
        end
        slow <= 1'b0;
        $display("test link input done");
        // status with the link input held off, then on
        hold <= 1'b1;
        @(posedge clk_sys);
        di_level <= 5'h0B;
        wr(8'h00, 32'h0000_0035);
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        rd(8'h0C, 32'(e_as * 32 + e_lk * 16 + e_rs * 4 + e_fs));
        @(posedge clk_sys);
        di_level <= 5'h10;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        rd(8'h0C, 32'(e_as * 32 + e_lk * 16 + e_rs * 4 + e_fs));
        hold <= 1'b0;
        $display("test status done");
        conclude();
    end
endmodule : command_source_select_test

// ---- tb/css_remote_model.sv ----
`timescale 1ns/1ps

// ------------------------------------------------------------
// remote controllers on both serial ports, fieldbus and CAN
// ------------------------------------------------------------
module css_remote_model (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic slow,
    output css_pkg::css_cmd_t ser1_cmd,
    output css_pkg::css_cmd_t ser2_cmd,
    output css_pkg::css_cmd_t fieldbus_cmd,
    output css_pkg::css_cmd_t can_cmd
);
    int gap;

    // a slow master refreshes its words only every fifth cycle, so the
    // selector is also seen holding one remote value for several cycles
    always @(posedge clk_sys)
    begin
        if (!rst_b || gap == 0)
        begin
            ser1_cmd <= css_pkg::css_cmd_t'($urandom);
            ser2_cmd <= css_pkg::css_cmd_t'($urandom);
            fieldbus_cmd <= css_pkg::css_cmd_t'($urandom);
            can_cmd <= css_pkg::css_cmd_t'($urandom);
            gap <= slow ? 4 : 0;
        end
        else
        begin
            gap <= gap - 1;
        end
    end

    // defined words before the first edge
    initial
    begin
        gap = 0;
        ser1_cmd = '0;
        ser2_cmd = '0;
        fieldbus_cmd = '0;
        can_cmd = '0;
    end
endmodule : css_remote_model
